/* xfer_engine_map.vh */
/*
 * register index map, field positions and reset values of the two-channel
 * transfer engine. assumes inclusion by bare name from the design files.
 */
`ifndef XFER_ENGINE_MAP_VH
`define XFER_ENGINE_MAP_VH

// direct local ports, chosen by the two local address lines
`define LOC_DATA 2'h0
`define LOC_INDEX 2'h1
`define LOC_STATUS 2'h2

// index register fields
`define IDX_AUTOINC 7
`define IDX_CHAN 5

// offsets inside one channel window
`define OFS_BASE_ADDR0 5'h00
`define OFS_BASE_CNT0 5'h04
`define OFS_STROBE 5'h07
`define OFS_CUR_ADDR0 5'h08
`define OFS_CUR_CNT0 5'h0C
`define OFS_CONFIG 5'h10
`define OFS_STATUS 5'h11

// length-and-control fields
`define CNT_START 23
`define CNT_DIR 22
`define CNT_MSB 21
`define CNT_FULL 23'h400000

// configuration bits
`define CFG_BURST 0
`define CFG_SUSPEND 1
`define CFG_CLEAR 2

// channel status bits
`define STS_ACTIVE 0
`define STS_DONE 1
`define STS_MISMATCH 2
`define STS_WIDE16 3

// reset values
`define RST_BYTE 8'h00
`define RST_ADDR 32'h00000000
`define RST_CNT 24'h000000
`define RST_CUR_CNT 23'h000000
`define RST_BE 4'hF

// synchroniser reset levels: bclk, slburst_n, ex32_n, exrdy, data
`define SYNC_INIT {1'b0, 1'b1, 1'b1, 1'b1, 32'h00000000}

`endif

/* pin_filter.v */
/*
 * three-stage input filter with an output flop, one chain per bit.
 * assumes asynchronous inputs; a change is taken once stages two and three agree.
 */
`timescale 1ns/1ps
module pin_filter #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // pins
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : bit_chain
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          s1_reg <= INIT[i];
          s2_reg <= INIT[i];
          s3_reg <= INIT[i];
          out_reg <= INIT[i];
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign pin_out[i] = out_reg;
    end
  endgenerate
endmodule

/* dual_channel_eisa_transfer_engine.v */
/*
 * two-channel bus-master transfer engine: indexed local register access,
 * per-channel base/current/control groups and one bus cycle sequencer.
 * assumes bus pins and bclk are asynchronous to clk_sys; pads resolve enables.
 */
// Overview of operation
// - two independent channels, burst or two-clock cycles
// - fall back to non-burst or mismatched cycles
// - base, current and control groups per channel
// - seven base bytes: address and length
// - lengths from one byte to four megabytes
// - count top bit starts, next sets direction
// - current group loaded from base, readable
// - strobe write loads current, raises request if start bit set
// - strobe during transfer defers load until done
// - busy flags in local status bits 0, 1
// - configuration write can terminate running transfer
// - burst selection comes from configuration register
// - no slave burst: keep master burst inactive
// - burst selected: master16 low one bclk from start edge
// - burst downshifts to 16 bits without ex32
// - non-burst without ex32: float start, lanes, data
// - wait for ex32 return before next address
// - ex32 active: 32-bit two-clock cycle
`timescale 1ns/1ps
`include "xfer_engine_map.vh"
module dual_channel_eisa_transfer_engine (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // local processor port
  input wire [1:0] local_addr,
  input wire [7:0] local_wdata,
  input wire local_wr,
  input wire local_rd,
  output reg [7:0] local_rdata,
  // bus inputs
  input wire bclk,
  input wire slburst_n,
  input wire ex32_n,
  input wire exrdy,
  input wire [31:0] multiplexed_data_bus_in,
  // bus outputs
  output reg start_n,
  output reg start_oe,
  output reg msburst_n,
  output reg master16_n,
  output reg [3:0] byte_lane_enables,
  output reg byte_lane_oe,
  output reg [31:0] multiplexed_data_bus_out,
  output reg multiplexed_data_bus_oe,
  output reg [31:2] eisa_addr,
  output reg mem_write,
  // board data side
  input wire [31:0] board_wdata,
  output reg board_take,
  output reg [31:0] board_rdata,
  output reg board_valid
);
  localparam E_IDLE = 3'd0;
  localparam E_ARM = 3'd1;
  localparam E_CMD = 3'd2;
  localparam E_DATA = 3'd3;
  localparam E_BACK = 3'd4;
  localparam E_END = 3'd5;

  wire [35:0] filt;
  pin_filter #(.W(36), .INIT(`SYNC_INIT)) u_filter (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in({bclk, slburst_n, ex32_n, exrdy, multiplexed_data_bus_in}),
    .pin_out(filt)
  );
  wire bclk_f = filt[35];
  wire slburst_f = filt[34];
  wire ex32_f = filt[33];
  wire exrdy_f = filt[32];
  wire [31:0] data_f = filt[31:0];

  reg bclk_last_reg;
  wire bclk_rise = bclk_f & ~bclk_last_reg;

  // register storage
  reg [7:0] index_reg;
  reg [31:0] base_addr_reg [0:1];
  reg [23:0] base_cnt_reg [0:1];
  reg [7:0] cfg_reg [0:1];
  reg [31:0] cur_addr_reg [0:1];
  reg [22:0] cur_cnt_reg [0:1];
  reg [1:0] active_reg;
  reg [1:0] pending_reg;
  reg [1:0] dir_reg;
  reg [1:0] done_reg;
  reg [1:0] mism_reg;
  wire [1:0] req;

  // sequencer state
  reg [2:0] state_reg;
  reg ch_reg;
  reg last_ch_reg;
  reg burst_reg;
  reg wide16_reg;
  reg adv_reg;
  reg [2:0] adv_bytes_reg;

  wire data_wr = local_wr & (local_addr == `LOC_DATA);
  wire data_rd = local_rd & (local_addr == `LOC_DATA);
  wire [4:0] ofs = index_reg[4:0];
  wire [1:0] busy = active_reg | pending_reg;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      index_reg <= `RST_BYTE;
    end else if (local_wr & (local_addr == `LOC_INDEX)) begin
      index_reg <= local_wdata;
    end else if ((data_wr | data_rd) & index_reg[`IDX_AUTOINC]) begin
      index_reg <= {1'b1, index_reg[6:0] + 7'h01};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire sel = (index_reg[6] == 1'b0) & (index_reg[`IDX_CHAN] == g);
      wire wr = data_wr & sel;
      wire strobe_wr = wr & (ofs == `OFS_STROBE);
      wire cfg_wr = wr & (ofs == `OFS_CONFIG);
      wire adv = adv_reg & (ch_reg == g);
      wire [22:0] step = {20'h00000, adv_bytes_reg};
      wire fin = adv & (cur_cnt_reg[g] <= step);
      wire term = cfg_wr & local_wdata[`CFG_CLEAR] & active_reg[g];
      wire load = (strobe_wr & (~active_reg[g] | fin)) | (fin & pending_reg[g]);
      wire [21:0] len = base_cnt_reg[g][`CNT_MSB:0];
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          base_addr_reg[g] <= `RST_ADDR;
          base_cnt_reg[g] <= `RST_CNT;
          cfg_reg[g] <= `RST_BYTE;
          cur_addr_reg[g] <= `RST_ADDR;
          cur_cnt_reg[g] <= `RST_CUR_CNT;
          active_reg[g] <= 1'b0;
          pending_reg[g] <= 1'b0;
          dir_reg[g] <= 1'b0;
          done_reg[g] <= 1'b0;
          mism_reg[g] <= 1'b0;
        end else begin
          // base bytes written without a busy check
          if (wr & (ofs[4:2] == 3'b000)) begin
            base_addr_reg[g][ofs[1:0]*8 +: 8] <= local_wdata;
          end
          if (wr & (ofs[4:2] == 3'b001) & (ofs[1:0] != 2'b11)) begin
            base_cnt_reg[g][ofs[1:0]*8 +: 8] <= local_wdata;
          end
          if (cfg_wr) begin
            cfg_reg[g] <= {5'h00, local_wdata[2:0]};
          end
          if (load) begin
            cur_addr_reg[g] <= base_addr_reg[g];
            // zero length encodes the full four megabytes
            cur_cnt_reg[g] <= (len == 22'h000000) ? `CNT_FULL : {1'b0, len};
            dir_reg[g] <= base_cnt_reg[g][`CNT_DIR];
            active_reg[g] <= base_cnt_reg[g][`CNT_START];
            pending_reg[g] <= 1'b0;
            done_reg[g] <= 1'b0;
          end else if (strobe_wr) begin
            pending_reg[g] <= 1'b1;
          end else if (term) begin
            active_reg[g] <= 1'b0;
            cur_cnt_reg[g] <= `RST_CUR_CNT;
          end else if (adv) begin
            cur_addr_reg[g] <= cur_addr_reg[g] + {29'h00000000, adv_bytes_reg};
            cur_cnt_reg[g] <= fin ? `RST_CUR_CNT : cur_cnt_reg[g] - step;
            if (fin) begin
              active_reg[g] <= 1'b0;
              done_reg[g] <= 1'b1;
            end
          end
          if (adv) begin
            // start is floated only on a backed-off cycle
            mism_reg[g] <= ~start_oe;
          end
        end
      end
      assign req[g] = active_reg[g] & ~cfg_reg[g][`CFG_SUSPEND] & ~term;
    end
  endgenerate

  // local read path
  wire ich = index_reg[`IDX_CHAN];
  reg [7:0] idx_data;
  always @* begin
    idx_data = 8'h00;
    if (index_reg[6] == 1'b0) begin
      case (ofs)
        5'h00, 5'h01, 5'h02, 5'h03: idx_data = base_addr_reg[ich][ofs[1:0]*8 +: 8];
        5'h04, 5'h05, 5'h06: idx_data = base_cnt_reg[ich][ofs[1:0]*8 +: 8];
        // current group is read live; software suspends first
        5'h08, 5'h09, 5'h0A, 5'h0B: idx_data = cur_addr_reg[ich][ofs[1:0]*8 +: 8];
        5'h0C: idx_data = cur_cnt_reg[ich][7:0];
        5'h0D: idx_data = cur_cnt_reg[ich][15:8];
        5'h0E: idx_data = {1'b0, cur_cnt_reg[ich][22:16]};
        `OFS_CONFIG: idx_data = cfg_reg[ich];
        `OFS_STATUS: idx_data = {4'h0, wide16_reg & (ch_reg == ich), mism_reg[ich],
                                 done_reg[ich], active_reg[ich]};
        default: idx_data = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      local_rdata <= `RST_BYTE;
    end else if (local_rd) begin
      case (local_addr)
        `LOC_DATA: local_rdata <= idx_data;
        `LOC_INDEX: local_rdata <= index_reg;
        `LOC_STATUS: local_rdata <= {6'h00, busy};
        default: local_rdata <= 8'h00;
      endcase
    end
  end

  // bytes of the coming cycle and their lane enables
  wire [22:0] rem = cur_cnt_reg[ch_reg];
  wire [2:0] wmax = wide16_reg ? 3'd2 : 3'd4;
  wire [2:0] nbytes = (rem < {20'h00000, wmax}) ? rem[2:0] : wmax;
  reg [3:0] be_n;
  always @* begin
    case (nbytes)
      3'd1: be_n = 4'hE;
      3'd2: be_n = 4'hC;
      3'd3: be_n = 4'h8;
      3'd4: be_n = 4'h0;
      default: be_n = `RST_BE;
    endcase
  end
  wire pick = (req[~last_ch_reg]) ? ~last_ch_reg : last_ch_reg;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bclk_last_reg <= 1'b0;
      state_reg <= E_IDLE;
      ch_reg <= 1'b0;
      last_ch_reg <= 1'b1;
      burst_reg <= 1'b0;
      wide16_reg <= 1'b0;
      adv_reg <= 1'b0;
      adv_bytes_reg <= 3'd0;
      start_n <= 1'b1;
      start_oe <= 1'b0;
      msburst_n <= 1'b1;
      master16_n <= 1'b1;
      byte_lane_enables <= `RST_BE;
      byte_lane_oe <= 1'b0;
      multiplexed_data_bus_out <= 32'h00000000;
      multiplexed_data_bus_oe <= 1'b0;
      eisa_addr <= 30'h00000000;
      mem_write <= 1'b0;
      board_take <= 1'b0;
      board_rdata <= 32'h00000000;
      board_valid <= 1'b0;
    end else begin
      bclk_last_reg <= bclk_f;
      adv_reg <= 1'b0;
      board_take <= 1'b0;
      board_valid <= 1'b0;
      case (state_reg)
        E_IDLE: begin
          wide16_reg <= 1'b0;
          if (req != 2'b00) begin
            ch_reg <= pick;
            last_ch_reg <= pick;
            burst_reg <= cfg_reg[pick][`CFG_BURST];
            eisa_addr <= cur_addr_reg[pick][31:2];
            mem_write <= dir_reg[pick];
            start_oe <= 1'b1;
            byte_lane_oe <= 1'b1;
            state_reg <= E_ARM;
          end
        end
        E_ARM: begin
          byte_lane_enables <= be_n;
          multiplexed_data_bus_out <= board_wdata;
          multiplexed_data_bus_oe <= mem_write;
          if (bclk_rise) begin
            start_n <= 1'b0;
            master16_n <= ~burst_reg;
            state_reg <= E_CMD;
          end
        end
        E_CMD: begin
          if (bclk_rise) begin
            start_n <= 1'b1;
            master16_n <= 1'b1;
            if (burst_reg & ~slburst_f) begin
              msburst_n <= 1'b0;
              wide16_reg <= ex32_f;
              state_reg <= E_DATA;
            end else if (~ex32_f) begin
              burst_reg <= 1'b0;
              state_reg <= E_DATA;
            end else begin
              burst_reg <= 1'b0;
              start_oe <= 1'b0;
              byte_lane_oe <= 1'b0;
              multiplexed_data_bus_oe <= 1'b0;
              state_reg <= E_BACK;
            end
          end
        end
        E_DATA: begin
          if (wide16_reg) begin
            byte_lane_enables <= be_n;
          end
          if (bclk_rise & exrdy_f) begin
            adv_reg <= 1'b1;
            adv_bytes_reg <= nbytes;
            board_take <= mem_write;
            board_valid <= ~mem_write;
            board_rdata <= data_f;
            if (burst_reg & (rem > {20'h00000, nbytes}) & req[ch_reg]) begin
              state_reg <= E_END;
            end else begin
              msburst_n <= 1'b1;
              state_reg <= E_END;
            end
          end
        end
        E_BACK: begin
          if (bclk_rise & ~ex32_f) begin
            adv_reg <= 1'b1;
            adv_bytes_reg <= nbytes;
            board_valid <= ~mem_write;
            board_rdata <= data_f;
            board_take <= mem_write;
            state_reg <= E_END;
          end
        end
        E_END: begin
          // wait out the current group update, then release or continue
          if (adv_reg) begin
            state_reg <= E_END;
          end else if (~msburst_n & req[ch_reg]) begin
            eisa_addr <= cur_addr_reg[ch_reg][31:2];
            byte_lane_enables <= be_n;
            multiplexed_data_bus_out <= board_wdata;
            state_reg <= E_DATA;
          end else begin
            msburst_n <= 1'b1;
            start_oe <= 1'b0;
            byte_lane_oe <= 1'b0;
            multiplexed_data_bus_oe <= 1'b0;
            byte_lane_enables <= `RST_BE;
            state_reg <= E_IDLE;
          end
        end
        default: state_reg <= E_IDLE;
      endcase
    end
  end
endmodule

/* xfer_engine_props.sv */
/* bus pin and local read port checker for the transfer engine.
   assumes bclk runs 25 clk_sys cycles a period; bound by port name. */
`timescale 1ns/1ps
module xfer_engine_props (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // local port
  input wire local_rd,
  input wire [7:0] local_rdata,
  // bus pins
  input wire slburst_n,
  input wire start_n,
  input wire start_oe,
  input wire msburst_n,
  input wire master16_n,
  input wire byte_lane_oe,
  input wire multiplexed_data_bus_oe,
  input wire mem_write,
  // board side
  input wire board_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  m16_with_start_a: assert property ($fell(master16_n) |-> $fell(start_n))
    else $error("master16 not launched with start");
  m16_one_bclk_a: assert property ($fell(master16_n) |-> ##[23:27] $rose(master16_n))
    else $error("master16 low not one bus clock");
  start_one_bclk_a: assert property ($fell(start_n) |-> ##[23:27] $rose(start_n))
    else $error("start low not one bus clock");
  burst_needs_slave_a: assert property (!msburst_n |-> !slburst_n)
    else $error("master burst without slave burst");
  float_together_a: assert property ($fell(start_oe) |->
    ##[0:2] (!byte_lane_oe && !multiplexed_data_bus_oe))
    else $error("lanes or data still driven after start floated");
  data_drive_dir_a: assert property (multiplexed_data_bus_oe |-> mem_write)
    else $error("data driven on a read cycle");
  rdata_stands_a: assert property (!$past(local_rd) |-> $stable(local_rdata))
    else $error("read data changed without a read");
  valid_pulse_a: assert property (board_valid |=> !board_valid)
    else $error("board valid longer than one cycle");
endmodule

bind dual_channel_eisa_transfer_engine xfer_engine_props i_xfer_engine_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .local_rd(local_rd), .local_rdata(local_rdata),
  .slburst_n(slburst_n), .start_n(start_n), .start_oe(start_oe), .msburst_n(msburst_n),
  .master16_n(master16_n), .byte_lane_oe(byte_lane_oe),
  .multiplexed_data_bus_oe(multiplexed_data_bus_oe), .mem_write(mem_write),
  .board_valid(board_valid));

/* eisa_slave_model.sv */
/* free running bus clock, memory slave and bus controller stand-in.
   assumes start_n and start_oe of the engine seen as driven. */
`timescale 1ns/1ps
module eisa_slave_model (
  // engine side
  input wire start_n,
  input wire start_oe,
  input wire msburst_n,
  // response settings
  input wire burst_ok,
  input wire wide32,
  input wire slow,
  // bus lines
  output logic bclk,
  output logic slburst_n,
  output logic ex32_n,
  output logic exrdy,
  output logic [31:0] data_in
);
  int mis;
  int wt;
  initial begin
    bclk = 1'b0;
    slburst_n = 1'b1;
    ex32_n = 1'b1;
    exrdy = 1'b1;
    data_in = 32'h00000001;
    mis = 0;
    wt = 0;
    #17;
    forever #62.5 bclk = ~bclk;
  end
  // read data pattern changes every bus clock
  always @(negedge bclk) begin
    data_in <= {data_in[30:0], ~data_in[31]};
    exrdy <= (wt == 0);
    if (wt > 0)
      wt <= wt - 1;
    if (start_oe && !start_n) begin
      slburst_n <= !burst_ok;
      ex32_n <= !wide32;
      mis <= wide32 ? 0 : 3;
      wt <= slow ? 2 : 0;
    end else if (mis == 1 && msburst_n) begin
      ex32_n <= 1'b0;
      mis <= 0;
    end else if (mis > 1) begin
      mis <= mis - 1;
    end
  end
endmodule

/* dual_channel_eisa_transfer_engine_test.sv */
/* self-checking bench: register programming, eight cycle kinds, deferred
   strobe, clear and a 4 MB load. assumes the slave model and map header. */
`timescale 1ns/1ps
`include "xfer_engine_map.vh"
module dual_channel_eisa_transfer_engine_test;
  logic clk_sys, reset_n, local_wr, local_rd, burst_ok, wide32, slow;
  logic [1:0] local_addr;
  logic [7:0] local_wdata, local_rdata, v;
  logic bclk, slburst_n, ex32_n, exrdy, start_n, start_oe, msburst_n, master16_n;
  logic byte_lane_oe, dbus_oe, mem_write, board_take, board_valid;
  logic [3:0] byte_lane_enables;
  logic [31:0] dbus_in, dbus_out, dbus_far, board_wdata, board_rdata, a, ca;
  logic [31:2] eisa_addr;
  logic [23:0] cc;
  logic [21:0] len;
  logic [5:0] t;
  logic [5:0] tbl [0:7] = '{6'h02, 6'h33, 6'h2E, 6'h0C, 6'h3B, 6'h00, 6'h36, 6'h31};
  logic trk;
  logic [31:0] ea;
  integer seed, bad_count, cmp_count, nv, nt, i, w, er;
  assign dbus_in = dbus_oe ? dbus_out : dbus_far;
  dual_channel_eisa_transfer_engine i_dual_channel_eisa_transfer_engine (
    .clk_sys(clk_sys), .reset_n(reset_n), .local_addr(local_addr),
    .local_wdata(local_wdata), .local_wr(local_wr), .local_rd(local_rd),
    .local_rdata(local_rdata), .bclk(bclk), .slburst_n(slburst_n), .ex32_n(ex32_n),
    .exrdy(exrdy), .multiplexed_data_bus_in(dbus_in), .start_n(start_n),
    .start_oe(start_oe), .msburst_n(msburst_n), .master16_n(master16_n),
    .byte_lane_enables(byte_lane_enables), .byte_lane_oe(byte_lane_oe),
    .multiplexed_data_bus_out(dbus_out), .multiplexed_data_bus_oe(dbus_oe),
    .eisa_addr(eisa_addr), .mem_write(mem_write), .board_wdata(board_wdata),
    .board_take(board_take), .board_rdata(board_rdata), .board_valid(board_valid));
  eisa_slave_model i_eisa_slave_model (
    .start_n(start_oe ? start_n : 1'b1), .start_oe(start_oe), .msburst_n(msburst_n),
    .burst_ok(burst_ok), .wide32(wide32), .slow(slow), .bclk(bclk),
    .slburst_n(slburst_n), .ex32_n(ex32_n), .exrdy(exrdy), .data_in(dbus_far));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (board_valid === 1'b1) begin
      nv <= nv + 1;
      chk(board_rdata, dbus_far);
    end
    if (board_take === 1'b1) begin
      nt <= nt + 1;
      chk(dbus_out, board_wdata);
      board_wdata <= $random(seed);
    end
    if (trk === 1'b1 && (board_valid === 1'b1 || board_take === 1'b1)) begin
      chk(eisa_addr, ea[31:2]);
      chk(byte_lane_enables, lanes((er < w) ? er : w));
      ea = ea + w;
      er = er - w;
    end
  end
  function automatic [7:0] idx(input logic ch, input logic [4:0] o);
    idx = {2'b10, ch, o};
  endfunction
  function automatic [3:0] lanes(input integer n);
    case (n)
      1: lanes = 4'hE;
      2: lanes = 4'hC;
      3: lanes = 4'h8;
      default: lanes = 4'h0;
    endcase
  endfunction
  task results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      $display("unexpected %0t got %h want %h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask
  task wr(input logic [1:0] ad, input logic [7:0] d);
    local_addr <= ad;
    local_wdata <= d;
    local_wr <= 1'b1;
    @(posedge clk_sys);
    local_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [1:0] ad);
    local_addr <= ad;
    local_rd <= 1'b1;
    @(posedge clk_sys);
    local_rd <= 1'b0;
    @(posedge clk_sys);
    v = local_rdata;
  endtask
  task prog(input logic ch, input logic [31:0] ad, input logic [21:0] n,
            input logic go, input logic d);
    wr(`LOC_INDEX, idx(ch, `OFS_BASE_ADDR0));
    for (int k = 0; k < 4; k++)
      wr(`LOC_DATA, ad[8*k +: 8]);
    wr(`LOC_DATA, n[7:0]);
    wr(`LOC_DATA, n[15:8]);
    wr(`LOC_DATA, {go, d, n[21:16]});
    wr(`LOC_DATA, 8'h00);
  endtask
  task rdcur(input logic ch);
    wr(`LOC_INDEX, idx(ch, `OFS_CUR_ADDR0));
    for (int k = 0; k < 7; k++) begin
      rd(`LOC_DATA);
      if (k < 4)
        ca[8*k +: 8] = v;
      else
        cc[8*(k-4) +: 8] = v;
    end
  endtask
  task wait_idle(input logic ch);
    for (i = 0; i < 3000; i++) begin
      rd(`LOC_STATUS);
      if (v[ch] === 1'b0)
        break;
      repeat (20) @(posedge clk_sys);
    end
    if (i == 3000) begin
      $display("unexpected %0t channel never went idle", $time);
      bad_count = bad_count + 1;
      results();
    end
  endtask
  task cfg(input logic ch, input logic [7:0] d);
    wr(`LOC_INDEX, idx(ch, `OFS_CONFIG));
    wr(`LOC_DATA, d);
  endtask
  initial begin
    seed = 32'h5ffa;
    bad_count = 0;
    cmp_count = 0;
    nv = 0;
    nt = 0;
    trk = 1'b0;
    ea = 32'h00000000;
    er = 0;
    w = 4;
    reset_n = 1'b0;
    local_wr = 1'b0;
    local_rd = 1'b0;
    local_addr = 2'h0;
    local_wdata = 8'h00;
    burst_ok = 1'b0;
    wide32 = 1'b1;
    slow = 1'b0;
    board_wdata = 32'h00000000;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(`LOC_STATUS);
    chk(v[1:0], 2'h0);
    rdcur(1'b0);
    chk(ca, 32'h00000000);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      t = tbl[c];
      burst_ok <= t[2];
      wide32 <= t[1];
      slow <= t[0];
      len = (c == 0) ? 22'h1 : 22'(($random(seed) & 32'hF) + 1);
      a = $random(seed);
      cfg(t[5], {7'h00, t[3]});
      rd(`LOC_STATUS);
      chk(v[t[5]], 1'b0);
      nv = 0;
      nt = 0;
      w = (t[3] && t[2] && !t[1]) ? 2 : 4;
      ea = a;
      er = len;
      trk = 1'b1;
      prog(t[5], a, len, 1'b1, t[4]);
      rd(`LOC_STATUS);
      chk(v[t[5]], 1'b1);
      wait_idle(t[5]);
      trk = 1'b0;
      rdcur(t[5]);
      chk(ca, a + len);
      chk(cc, 24'h000000);
      chk(t[4] ? nt : nv, (len + w - 1) / w);
      wr(`LOC_INDEX, idx(t[5], `OFS_STATUS));
      rd(`LOC_DATA);
      chk(v[3:0], {1'b0, !t[1] && !(t[3] && t[2]), 2'b10});
      $display("test case %0d done", c);
    end
    burst_ok <= 1'b0;
    wide32 <= 1'b1;
    slow <= 1'b0;
    nv = 0;
    a = $random(seed);
    prog(1'b0, a, 22'h8, 1'b1, 1'b0);
    wr(`LOC_INDEX, idx(1'b0, `OFS_STROBE));
    wr(`LOC_DATA, 8'h00);
    wait_idle(1'b0);
    chk(nv, 4);
    rdcur(1'b0);
    chk(ca, a + 32'h8);
    $display("test deferred strobe done");
    slow <= 1'b1;
    nv = 0;
    prog(1'b1, a, 22'h400, 1'b1, 1'b0);
    repeat (200) @(posedge clk_sys);
    cfg(1'b1, 8'h04);
    wait_idle(1'b1);
    rdcur(1'b1);
    chk(cc, 24'h000000);
    chk(nv < 256, 1'b1);
    cfg(1'b1, 8'h00);
    $display("test clear done");
    prog(1'b1, a, 22'h0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    rdcur(1'b1);
    chk(ca, a);
    chk(cc, 24'h400000);
    rd(`LOC_STATUS);
    chk(v[1], 1'b0);
    $display("test full length load done");
    results();
  end
endmodule
